// ---- design/srgs_params.svh ----
// timing figures, register offsets and sleep counts for the gate sequencer
`ifndef SRGS_PARAMS_SVH
`define SRGS_PARAMS_SVH

// clock rate and turn-on debounce, least time rounded up
`define CLK_MHZ 25
`define DEB_NS 250
`define DEB_CYC ((`DEB_NS * `CLK_MHZ + 999) / 1000)

// duty limits in percent of the switching cycle
`define LOW_PCT 40
`define HIGH_PCT 60

// confirmation and blanking counts in switching cycles
`define ENTER_N 16
`define EXIT_N 8
`define IGN_ENTER 128
`define IGN_EXIT 256
`define REV_N 2

// register map, byte addresses
`define REG_CTRL 4'h0
`define REG_STAT 4'h4
`define CTRL_EN_BIT 0
`define CTRL_RST 1'b1

`endif

// ---- design/srgs_pkg.sv ----
// types shared by the rectifier gate sequencer
package srgs_pkg;

   // digitised drain sense comparators of one rectifier switch
   typedef struct packed {
      logic arm;    // above arming level
      logic pt;     // below pretrigger level
      logic on;     // below on-trigger level
      logic off12;  // below the -12 mV turn-off level
      logic off25;  // below the -25 mV turn-off level
      logic zero;   // above zero, current reversing
   } cmp_t;

   // per-cycle report of one channel
   typedef struct packed {
      logic cyc_end;
      logic went_on;
      logic low;
      logic high;
      logic rev;
   } chan_rpt_t;

   typedef enum logic [2:0] {ST_WAIT, ST_PRE, ST_DEB, ST_ON, ST_DONE} gate_st_t;

endpackage

// ---- design/sense_sync.sv ----
// two-flop synchroniser for the comparator and enable inputs
`timescale 1ns/1ps
`default_nettype none
module sense_sync #(
   parameter int W = 8
)(
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         ce,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;

   // first stage feeds only the second
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_q <= '0;
         q      <= '0;
      end else if (ce) begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ---- design/gate_channel.sv ----
// one rectifier gate state machine with cycle and conduction timing
`timescale 1ns/1ps
`default_nettype none
`include "srgs_params.svh"
module gate_channel #(
   parameter int CNT_W = 12
)(
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire logic               ce,
   input  wire srgs_pkg::cmp_t     cmp,
   input  wire logic               arm_ev,
   input  wire logic               unlock,
   input  wire logic               drive,
   input  wire logic               hold,
   input  wire logic               sel25,
   output logic                    gate_q,
   output logic                    want,
   output srgs_pkg::chan_rpt_t     rpt_q
);
   import srgs_pkg::*;

   localparam int PW = CNT_W + 7;

   cmp_t             prev_q;
   gate_st_t         st_q;
   gate_st_t         st_d;
   logic [3:0]       deb_q;
   logic [CNT_W-1:0] cyc_q;
   logic [CNT_W-1:0] len_q;
   logic [CNT_W-1:0] cond_q;
   logic             run_q;
   logic             armed_q;
   logic             lock_q;
   logic             on_q;
   logic             rev_q;
   logic [3:0]       onrun_q;

   // ----------------------------------------------------------------
   // edges and comparator selection
   // ----------------------------------------------------------------
   wire              arm_rise = cmp.arm & ~prev_q.arm;
   wire              pt_fall  = cmp.pt & ~prev_q.pt;
   wire              on_rise  = cmp.on & ~prev_q.on;
   wire              idle     = (st_q == ST_WAIT) | (st_q == ST_PRE);
   wire [CNT_W-1:0]  half     = len_q >> 1;
   wire              second   = cond_q >= half;
   wire              off_sel  = sel25 ? cmp.off25 : cmp.off12;
   wire              deb_done = (st_q == ST_DEB) & cmp.on & (deb_q == 4'(`DEB_CYC - 1));
   assign want = deb_done & armed_q & ~lock_q & drive & ~hold;
   // zero comparator always, programmed one in second half
   wire              turn_off = (st_q == ST_ON) & (~drive | cmp.zero | (second & off_sel));
   wire              rev_hit  = (st_q == ST_ON) & cmp.zero & ~second;
   wire [PW-1:0]     c100     = PW'(cond_q) * PW'(100);
   wire [PW-1:0]     cyc_lo   = PW'(cyc_q) * PW'(`LOW_PCT);
   wire [PW-1:0]     cyc_hi   = PW'(cyc_q) * PW'(`HIGH_PCT);

   // ----------------------------------------------------------------
   // gate state machine; arming edge closes every cycle
   // ----------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      case (st_q)
         ST_WAIT: if (pt_fall) st_d = ST_PRE;
         ST_PRE: if (cmp.on) st_d = ST_DEB;
         ST_DEB: begin
            if (!cmp.on) st_d = ST_PRE;
            else if (want) st_d = ST_ON;
            else if (deb_done) st_d = ST_DONE;
         end
         ST_ON: if (turn_off) st_d = ST_DONE;
         ST_DONE: st_d = ST_DONE;
         default: st_d = ST_WAIT;
      endcase
      if (arm_rise) st_d = ST_WAIT;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prev_q <= '0;
         st_q   <= ST_WAIT;
         gate_q <= 1'b0;
         deb_q  <= '0;
      end else if (ce) begin
         prev_q <= cmp;
         st_q   <= st_d;
         gate_q <= st_d == ST_ON;
         deb_q  <= (st_q == ST_DEB) ? 4'(deb_q + 4'd1) : 4'd0;
      end
   end

   // ----------------------------------------------------------------
   // arming, one switching per cycle, per-cycle flags; sets win
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         armed_q <= 1'b0;
         lock_q  <= 1'b0;
         on_q    <= 1'b0;
         rev_q   <= 1'b0;
      end else if (ce) begin
         armed_q <= arm_ev | (armed_q & ~want);
         lock_q  <= turn_off | (lock_q & ~unlock);
         on_q    <= want | (on_q & ~arm_rise);
         rev_q   <= rev_hit | (rev_q & ~arm_rise);
      end
   end

   // ----------------------------------------------------------------
   // timing counters, all saturating
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cyc_q  <= '0;
         len_q  <= '0;
         cond_q <= '0;
         run_q  <= 1'b0;
      end else if (ce) begin
         cyc_q <= pt_fall ? '0 : ((&cyc_q) ? cyc_q : cyc_q + 1'b1);
         if (arm_rise) len_q <= cyc_q;
         // conduction, ends at turn-off or on level lost
         run_q <= (on_rise & idle) | (run_q & ~turn_off & ~arm_rise & (cmp.on | st_q == ST_ON));
         if (on_rise & idle) cond_q <= '0;
         else if (run_q & ~(&cond_q)) cond_q <= cond_q + 1'b1;
      end
   end

   // report duty of the closed cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rpt_q <= '0;
      end else if (ce) begin
         rpt_q.cyc_end <= arm_rise;
         rpt_q.went_on <= on_q | want;
         rpt_q.low     <= c100 < cyc_lo;
         rpt_q.high    <= c100 > cyc_hi;
         rpt_q.rev     <= rev_q | rev_hit;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) onrun_q <= '0;
      else if (ce) onrun_q <= cmp.on ? ((&onrun_q) ? onrun_q : 4'(onrun_q + 4'd1)) : 4'd0;
   end

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   property p_debounce;
      $rose(gate_q) |-> onrun_q >= 4'(`DEB_CYC + 1);
   endproperty
   a_debounce: assert property (p_debounce) else $error("gate on before debounce");
   property p_armed;
      $rose(gate_q) |-> $past(armed_q);
   endproperty
   a_armed: assert property (p_armed) else $error("gate on without arming");
   property p_unlocked;
      $rose(gate_q) |-> !$past(lock_q);
   endproperty
   a_unlocked: assert property (p_unlocked) else $error("second switching in a cycle");
   property p_half;
      $fell(gate_q) |-> $past(arm_rise) || !$past(drive) || $past(cmp.zero) || $past(second);
   endproperty
   a_half: assert property (p_half) else $error("turn-off in first half");
   c_gate_on: cover property ($rose(gate_q));
endmodule
`default_nettype wire

// ---- design/sync_rectifier_gate_sequencer.sv ----
// top: interlocked rectifier gate channels, sleep control and register slave
//
// Overview of operation
// - two gate machines run together; both gates never on at once
// - opposite drain rising past arming level arms a channel; no arming, no turn-on
// - drain falling below pretrigger level prepares that channel for turn-on
// - on-trigger comparator event requests turn-on of that channel
// - on-trigger must persist longer than 250 ns before the gate rises
// - programmed turn-off acts only in second half, from previous cycle length
// - in first half only the zero comparator turns the gate off
// - turn-off threshold is -12 mV or -25 mV, chosen by enable bias
// - body-diode retrigger after turn-off does not turn the gate on again
// - after turn-off, no turn-on until the other channel finished its cycle
// - a channel missing turn-on suppresses the other channel next cycle
// - cycle length runs from pretrigger falling to arming rising
// - conduction runs from on-trigger to turn-off, or to on level lost
// - conduction under 40% of cycle is light load; sleep stops both gates
// - sleep entered after 16 consecutive light cycles on both channels
// - sleep left after 8 consecutive cycles above 60% on both channels
// - duty ignored 128 cycles after entering, 256 after leaving sleep
// - reversal on two consecutive cycles forces sleep until safe again
// - threshold choice taken once after reset, -25 mV if enable low
// - gates driven only while enable is above its on level
//
// Design decisions made here: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "srgs_params.svh"
module sync_rectifier_gate_sequencer #(
   parameter int CNT_W   = 12,
   parameter int ENTER_N = `ENTER_N,
   parameter int EXIT_N  = `EXIT_N
)(
   input  wire logic            CLOCK,
   input  wire logic            RESET,
   input  wire logic            CE,
   input  wire srgs_pkg::cmp_t  DRAIN_SENSE_A,
   input  wire srgs_pkg::cmp_t  DRAIN_SENSE_B,
   input  wire logic            EN_ON,
   input  wire logic            EN_THR,
   input  wire logic [3:0]      AVS_ADDRESS,
   input  wire logic            AVS_READ,
   input  wire logic            AVS_WRITE,
   input  wire logic [31:0]     AVS_WRITEDATA,
   input  wire logic [3:0]      AVS_BYTEENABLE,
   output logic      [31:0]     AVS_READDATA,
   output logic                 AVS_WAITREQUEST,
   output logic                 GATE_OUT_A,
   output logic                 GATE_OUT_B,
   output logic                 SLEEP
);
   import srgs_pkg::*;

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [13:0] raw;
   logic [13:0] syn;
   cmp_t        sense [2];
   chan_rpt_t   rpt [2];
   logic [1:0]  gate;
   logic [1:0]  want;
   logic [1:0]  hold;
   logic [1:0]  miss;
   logic [1:0]  block_q;
   logic [4:0]  low_n [2];
   logic [3:0]  high_n [2];
   logic [1:0]  rev_n;
   logic [8:0]  ign_q;
   logic        sleep_q;
   logic        en_on_s;
   logic        en_thr_s;
   logic [1:0]  sel_wait_q;
   logic        sel_done_q;
   logic        sel25_q;
   logic        ctrl_en_q;
   logic        ack_q;
   logic [31:0] rdata_q;
   logic        drive;
   logic        ign_busy;
   logic        enter;
   logic        leave;

   // ----------------------------------------------------------------
   // input synchronisation
   // ----------------------------------------------------------------
   assign raw = {EN_THR, EN_ON, DRAIN_SENSE_B, DRAIN_SENSE_A};

   sense_sync #(
      .W (14)
   ) u_sync (
      .clk (CLOCK),
      .rst (RESET),
      .ce  (CE),
      .d   (raw),
      .q   (syn)
   );

   assign sense[0] = cmp_t'(syn[5:0]);
   assign sense[1] = cmp_t'(syn[11:6]);
   assign en_on_s  = syn[12];
   assign en_thr_s = syn[13];

   // ----------------------------------------------------------------
   // turn-off threshold strap
   // ----------------------------------------------------------------
   // waits for the synchroniser to fill so that a reset value is never taken
   // captured once, held until reset
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         sel_wait_q <= 2'h0;
         sel_done_q <= 1'b0;
         sel25_q    <= 1'b0;
      end else if (CE & ~sel_done_q) begin
         sel_wait_q <= 2'(sel_wait_q + 2'h1);
         if (sel_wait_q == 2'h2) begin
            sel_done_q <= 1'b1;
            sel25_q    <= ~en_thr_s;
         end
      end
   end

   // ----------------------------------------------------------------
   // gate enable and channel interlock
   // ----------------------------------------------------------------
   // enable level, software enable, threshold choice taken, not asleep
   assign drive = en_on_s & ctrl_en_q & sel_done_q & ~sleep_q;

   // channel a wins a tie; neither rises while the other is on
   assign hold[0] = block_q[0] | gate[1];
   assign hold[1] = block_q[1] | gate[0] | want[0];

   genvar i;
   generate
      for (i = 0; i < 2; i++) begin : g_ch
         gate_channel #(
            .CNT_W (CNT_W)
         ) u_ch (
            .clk    (CLOCK),
            .rst    (RESET),
            .ce     (CE),
            .cmp    (sense[i]),
            .arm_ev (rpt[1-i].cyc_end),
            .unlock (rpt[1-i].cyc_end),
            .drive  (drive),
            .hold   (hold[i]),
            .sel25  (sel25_q),
            .gate_q (gate[i]),
            .want   (want[i]),
            .rpt_q  (rpt[i])
         );

         // a miss caused by suppression itself does not propagate
         assign miss[i] = rpt[i].cyc_end & ~rpt[i].went_on & drive & ~block_q[i];

         // suppress for one cycle; set wins
         always_ff @(posedge CLOCK or posedge RESET) begin
            if (RESET) block_q[i] <= 1'b0;
            else if (CE) block_q[i] <= miss[1-i] | (block_q[i] & ~rpt[i].cyc_end);
         end

         // consecutive light and heavy cycles per channel
         always_ff @(posedge CLOCK or posedge RESET) begin
            if (RESET) begin
               low_n[i]  <= 5'h0;
               high_n[i] <= 4'h0;
            end else if (CE) begin
               if (enter | leave | ign_busy) begin
                  low_n[i]  <= 5'h0;
                  high_n[i] <= 4'h0;
               end else if (rpt[i].cyc_end) begin
                  if (!rpt[i].low) low_n[i] <= 5'h0;
                  else if (low_n[i] < 5'(ENTER_N)) low_n[i] <= 5'(low_n[i] + 5'h1);
                  if (!rpt[i].high) high_n[i] <= 4'h0;
                  else if (high_n[i] < 4'(EXIT_N)) high_n[i] <= 4'(high_n[i] + 4'h1);
               end
            end
         end
      end
   endgenerate

   assign GATE_OUT_A = gate[0];
   assign GATE_OUT_B = gate[1];
   assign SLEEP      = sleep_q;

   // ----------------------------------------------------------------
   // sleep control
   // ----------------------------------------------------------------
   assign ign_busy = ign_q != 9'h0;
   wire cyc_any  = rpt[0].cyc_end | rpt[1].cyc_end;
   wire rev_any  = (rpt[0].cyc_end & rpt[0].rev) | (rpt[1].cyc_end & rpt[1].rev);
   // two reversing cycles in a row
   wire rev_trip = rev_n >= 2'(`REV_N);
   wire light    = (low_n[0] >= 5'(ENTER_N)) & (low_n[1] >= 5'(ENTER_N)) & ~ign_busy;
   assign enter = ~sleep_q & (light | rev_trip);
   assign leave = sleep_q & ~ign_busy & (high_n[0] >= 4'(EXIT_N)) & (high_n[1] >= 4'(EXIT_N));

   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         rev_n <= 2'h0;
      end else if (CE) begin
         if (enter) rev_n <= 2'h0;
         else if (cyc_any) rev_n <= rev_any ? ((rev_trip) ? rev_n : 2'(rev_n + 2'h1)) : 2'h0;
      end
   end

   // blanking counts converter cycles, one per cycle of channel a
   // blank after each transition
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         sleep_q <= 1'b0;
         ign_q   <= 9'h0;
      end else if (CE) begin
         sleep_q <= enter | (sleep_q & ~leave);
         if (enter) ign_q <= 9'(`IGN_ENTER);
         else if (leave) ign_q <= 9'(`IGN_EXIT);
         else if (rpt[0].cyc_end & ign_busy) ign_q <= 9'(ign_q - 9'h1);
      end
   end

   // ----------------------------------------------------------------
   // avalon-mm slave, one wait state on every access
   // ----------------------------------------------------------------
   wire        req      = AVS_READ | AVS_WRITE;
   wire        hit_ctrl = AVS_ADDRESS == `REG_CTRL;
   wire        hit_stat = AVS_ADDRESS == `REG_STAT;
   wire [31:0] stat     = {24'h0, ign_busy, sel25_q, block_q, sleep_q, drive, gate};
   wire [31:0] rd_mux   = hit_ctrl ? {31'h0, ctrl_en_q} : (hit_stat ? stat : 32'h0);
   wire        wr_ctrl  = AVS_WRITE & ack_q & hit_ctrl & AVS_BYTEENABLE[0];

   assign AVS_WAITREQUEST = req & ~ack_q;
   assign AVS_READDATA    = rdata_q;

   // read data sampled in the wait cycle so it stands at the release edge
   always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
         ack_q     <= 1'b0;
         rdata_q   <= 32'h0;
         ctrl_en_q <= `CTRL_RST;
      end else if (CE) begin
         ack_q <= req & ~ack_q;
         if (req & ~ack_q) rdata_q <= rd_mux;
         if (wr_ctrl) ctrl_en_q <= AVS_WRITEDATA[`CTRL_EN_BIT];
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking @(posedge CLOCK); endclocking
   default disable iff (RESET);

   property p_interlock;
      !(gate[0] && gate[1]);
   endproperty
   a_interlock: assert property (p_interlock) else $error("both gates on");

   property p_sleep_off;
      (sleep_q && CE) |=> !(gate[0] || gate[1]);
   endproperty
   a_sleep_off: assert property (p_sleep_off) else $error("gate driven in sleep");

   property p_en_off;
      (!en_on_s && CE) |=> !(gate[0] || gate[1]);
   endproperty
   a_en_off: assert property (p_en_off) else $error("gate driven while disabled");

   property p_block;
      (block_q[1] && CE) |=> !$rose(gate[1]);
   endproperty
   a_block: assert property (p_block) else $error("suppressed channel turned on");

   property p_enter;
      $rose(sleep_q) |-> ($past(low_n[0]) >= 5'(ENTER_N) && $past(low_n[1]) >= 5'(ENTER_N))
                         || $past(rev_n) >= 2'(`REV_N);
   endproperty
   a_enter: assert property (p_enter) else $error("sleep without cause");

   property p_leave;
      $fell(sleep_q) |-> $past(high_n[0]) >= 4'(EXIT_N) && $past(high_n[1]) >= 4'(EXIT_N);
   endproperty
   a_leave: assert property (p_leave) else $error("wake without cause");

   property p_ign_enter;
      $rose(sleep_q) |-> ign_q == 9'(`IGN_ENTER);
   endproperty
   a_ign_enter: assert property (p_ign_enter) else $error("wrong blanking on entry");

   property p_ign_exit;
      $fell(sleep_q) |-> ign_q == 9'(`IGN_EXIT);
   endproperty
   a_ign_exit: assert property (p_ign_exit) else $error("wrong blanking on exit");

   property p_sel_hold;
      sel_done_q |=> $stable(sel25_q) && sel_done_q;
   endproperty
   a_sel_hold: assert property (p_sel_hold) else $error("threshold choice changed");

   c_sleep: cover property ($rose(sleep_q));
   c_wake: cover property ($fell(sleep_q));
   c_block: cover property ($rose(block_q[0]));
   c_gate_b: cover property ($rose(gate[1]));
endmodule
`default_nettype wire

// ---- testbench/rect_pair_model.sv ----
// behavioural pair of rectifier switches with drain comparators
`timescale 1ns/1ps
`default_nettype none
module rect_pair_model #(
   parameter int P = 48
)(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [7:0] cond,
   output srgs_pkg::cmp_t  a,
   output srgs_pkg::cmp_t  b
);
   import srgs_pkg::*;
   int   ph;
   int   k;
   cmp_t act;
   // --------------------------------
   // half-cycle phase, a then b
   // --------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ph <= 0;
      end else begin
         ph <= (ph == 2*P-1) ? 0 : ph + 1;
      end
   end
   assign k = (ph < P) ? ph : ph - P;
   always_comb begin
      act       = '0;
      act.pt    = (k >= 2) && (k < P-4);
      act.on    = (k >= 3) && (k < 3+cond);
      act.off12 = (k >= cond) && (k < 3+cond);
      act.off25 = (k >= cond+1) && (k < 3+cond);
   end
   // idle switch sits above the arming level, blocking so the other conducts
   assign a = (ph < P) ? act : cmp_t'(6'h20);
   assign b = (ph < P) ? cmp_t'(6'h20) : act;
endmodule
`default_nettype wire

// ---- testbench/sync_rectifier_gate_sequencer_tb.sv ----
// self-checking bench for the rectifier gate sequencer
`timescale 1ns/1ps
`default_nettype none
module sync_rectifier_gate_sequencer_tb;
   import srgs_pkg::*;
   logic        clock, reset, en_on, en_thr, rd_s, wr_s, wait_s, gate_a, gate_b, sleep, ga_q, gb_q;
   logic [3:0]  adr;
   logic [31:0] wdat, rdat, rd;
   logic [7:0]  cond;
   cmp_t        sense_a, sense_b;
   int          n_errors, compares, rise_a, rise_b, a0, b0;
   sync_rectifier_gate_sequencer DUT (.CLOCK(clock), .RESET(reset), .CE(1'b1), .DRAIN_SENSE_A(sense_a),
      .DRAIN_SENSE_B(sense_b), .EN_ON(en_on), .EN_THR(en_thr), .AVS_ADDRESS(adr), .AVS_READ(rd_s),
      .AVS_WRITE(wr_s), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdat),
      .AVS_WAITREQUEST(wait_s), .GATE_OUT_A(gate_a), .GATE_OUT_B(gate_b), .SLEEP(sleep));
   rect_pair_model model (.clk(clock), .rst(reset), .cond(cond), .a(sense_a), .b(sense_b));
   // --------------------------------
   // shared helpers
   // --------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // master holds the request until waitrequest is seen low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      rd_s <= !wr;
      wr_s <= wr;
      adr <= a;
      wdat <= d;
      @(posedge clock);
      while (wait_s !== 1'b0) @(posedge clock);
      q = rdat;
      rd_s <= 1'b0;
      wr_s <= 1'b0;
      @(posedge clock);
   endtask
   // rise counts are taken at the start so the caller sees rises inside the span
   task automatic halves(input int n);
      a0 = rise_a;
      b0 = rise_b;
      repeat (n*48) @(posedge clock);
   endtask
   // rise counting; both gates high is never legal
   always @(posedge clock) begin
      ga_q <= gate_a;
      gb_q <= gate_b;
      if (gate_a === 1'b1 && ga_q === 1'b0) rise_a++;
      if (gate_b === 1'b1 && gb_q === 1'b0) rise_b++;
      if (gate_a === 1'b1 && gate_b === 1'b1) check(2'b11, 2'b00);
   end
   // --------------------------------
   // scenarios
   // --------------------------------
   task automatic t_regs;
      bus(1'b0, 4'h0, 32'h0, rd); check(rd, 32'h1);
      bus(1'b0, 4'h4, 32'h0, rd); check(rd[6], 1'b0);
      bus(1'b0, 4'h8, 32'h0, rd); check(rd, 32'h0);
      $display("test regs done");
   endtask
   task automatic t_switch;
      halves(20);
      check(rise_a - a0 >= 8, 1'b1);
      check(rise_b - b0 >= 8, 1'b1);
      $display("test switch done");
   endtask
   task automatic t_enable;
      en_on <= 1'b0;
      // let the enable pass the synchroniser before counting rises
      repeat (4) @(posedge clock);
      halves(6); check(rise_a + rise_b - a0 - b0, 0);
      en_on <= 1'b1;
      bus(1'b1, 4'h0, 32'h0, rd);
      halves(6); check(rise_a + rise_b - a0 - b0, 0);
      bus(1'b0, 4'h0, 32'h0, rd); check(rd, 32'h0);
      bus(1'b1, 4'h0, 32'h1, rd);
      $display("test enable done");
   endtask
   // short on pulses: no turn-on, then light load puts it to sleep
   task automatic t_sleep;
      cond <= 8'd5;
      halves(2);
      halves(10); check(rise_a + rise_b - a0 - b0, 0);
      check(sleep, 1'b0);
      for (int i = 0; i < 60 && sleep !== 1'b1; i++) halves(1);
      check(sleep, 1'b1);
      cond <= 8'd38;
      halves(200); check(rise_a + rise_b - a0 - b0, 0);
      check(sleep, 1'b1);
      for (int i = 0; i < 200 && sleep !== 1'b0; i++) halves(1);
      check(sleep, 1'b0);
      halves(4); check(rise_a - a0 > 0, 1'b1);
      $display("test sleep done");
   endtask
   // strap low at a second reset selects -25 mV; raised just as the readback samples, before it passes the synchroniser
   task automatic t_strap;
      en_thr <= 1'b0;
      reset <= 1'b1;
      repeat (8) @(posedge clock);
      reset <= 1'b0;
      repeat (6) @(posedge clock);
      en_thr <= 1'b1;
      bus(1'b0, 4'h4, 32'h0, rd); check(rd[6], 1'b1);
      $display("test strap done");
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   initial begin
      {rd_s, wr_s, adr, wdat} = '0;
      {reset, en_on, en_thr, cond} = {3'b111, 8'd38};
      {n_errors, compares, rise_a, rise_b} = '0;
      repeat (8) @(posedge clock);
      reset <= 1'b0;
      repeat (6) @(posedge clock);
      t_regs();
      t_switch();
      t_enable();
      t_sleep();
      t_strap();
      summarize();
   end
   // hang guard, well above the expected run length
   initial begin
      repeat (60000) @(posedge clock);
      n_errors++;
      summarize();
   end
endmodule
`default_nettype wire
